// [cosr_pkg.sv]
// Summary of operation
// - drive enable low keeps clock pin released
// - rate select: 0 gives 8 kHz, 1 gives 2.048 MHz
// - rate select matters only while drive enabled
// - low summary bits 7..0 show channels 8..1
// - summary bit set while channel interrupt pending
// - high summary bits 6..0 show channels 15..9
// - summary bits follow per-channel interrupt sources
// - channel 0 summarised in bit 7 at 380H
package cosr_pkg;
	localparam logic [11:0] SUMMARY_LOW_ADDR = 12'h2C0;
	localparam logic [11:0] SUMMARY_HIGH_ADDR = 12'h300;
	localparam logic [11:0] SUMMARY_FIRST_ADDR = 12'h380;
	localparam logic [11:0] CLOCK_CTRL_ADDR = 12'h400;
	localparam int DRIVE_ENABLE_BIT = 3;
	localparam int RATE_SELECT_BIT = 2;
	localparam int FIRST_FLAG_BIT = 7;
	localparam logic [7:0] CLOCK_CTRL_RESET = 8'h04;
	localparam logic [7:0] CLOCK_CTRL_MASK = 8'h0C;
	localparam int NUM_CHANNELS = 16;
	localparam longint REF_CLK_HZ = 25000000;
	localparam longint FAST_RATE_HZ = 2048000;
	localparam longint SLOW_RATE_HZ = 8000;
	localparam int ACC_W = 24;
	localparam longint ACC_SPAN = 64'd1 << ACC_W;
	localparam logic [ACC_W-1:0] FAST_INC =
		ACC_W'((FAST_RATE_HZ * ACC_SPAN + REF_CLK_HZ / 2) / REF_CLK_HZ);
	localparam logic [ACC_W-1:0] SLOW_INC =
		ACC_W'((SLOW_RATE_HZ * ACC_SPAN + REF_CLK_HZ / 2) / REF_CLK_HZ);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [cosr_regs.sv]
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cosr_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [cosr_pkg::NUM_CHANNELS-1:0] channel_pending_flags,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic ref_clock_out,
	output logic ref_clock_out_oe
);
	import cosr_pkg::*;

	generate
		if (ADDR_W < 12) begin : g_bad_addr
			$error("cosr_regs: ADDR_W must be at least 12");
		end
	endgenerate

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] clock_output_control;
		logic [ACC_W-1:0] acc;
		logic clk_out;
		logic clk_oe;
	} cosr_state_t;

	cosr_state_t s;
	cosr_state_t next_s;

	logic [7:0] irq_source_summary_low;
	logic [7:0] irq_source_summary_high;
	logic [7:0] irq_source_summary_first;

	// summaries are pure views of the channel sources
	always_comb begin
		irq_source_summary_low = channel_pending_flags[8:1];
		irq_source_summary_high = {1'b0, channel_pending_flags[15:9]};
		irq_source_summary_first = 8'h00;
		irq_source_summary_first[FIRST_FLAG_BIT] = channel_pending_flags[0];
	end

	function automatic logic [11:0] word_addr(input logic [ADDR_W-1:0] a);
		word_addr = {a[11:2], 2'b00};
	endfunction

	always_comb begin
		next_s = s;
		// write address and data, either order
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
			next_s.awready = 1'b0;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wstrb0 = s_axi_wstrb[0];
			next_s.wready = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (word_addr(s.awaddr))
				CLOCK_CTRL_ADDR: begin
					if (s.wstrb0) begin
						next_s.clock_output_control = s.wdata & CLOCK_CTRL_MASK;
					end
				end
				SUMMARY_LOW_ADDR, SUMMARY_HIGH_ADDR, SUMMARY_FIRST_ADDR: begin
					next_s.bresp = RESP_OKAY;
				end
				default: begin
					next_s.bresp = RESP_DECERR;
				end
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		// read channel
		if (s.arready && s_axi_arvalid) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = 32'h0000_0000;
			case (word_addr(s_axi_araddr))
				SUMMARY_LOW_ADDR: begin
					next_s.rdata[7:0] = irq_source_summary_low;
				end
				SUMMARY_HIGH_ADDR: begin
					next_s.rdata[7:0] = irq_source_summary_high;
				end
				SUMMARY_FIRST_ADDR: begin
					next_s.rdata[7:0] = irq_source_summary_first;
				end
				CLOCK_CTRL_ADDR: begin
					next_s.rdata[7:0] = s.clock_output_control;
				end
				default: begin
					next_s.rresp = RESP_DECERR;
				end
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		// reference clock synthesiser, phase accumulator
		if (s.clock_output_control[DRIVE_ENABLE_BIT]) begin
			if (s.clock_output_control[RATE_SELECT_BIT]) begin
				next_s.acc = s.acc + FAST_INC;
			end else begin
				next_s.acc = s.acc + SLOW_INC;
			end
			next_s.clk_out = s.acc[ACC_W-1];
			next_s.clk_oe = 1'b1;
		end else begin
			next_s.acc = '0;
			next_s.clk_out = 1'b0;
			next_s.clk_oe = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.clock_output_control <= CLOCK_CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign ref_clock_out = s.clk_out;
	assign ref_clock_out_oe = s.clk_oe;
endmodule

// [cosr_regs_properties.sv]
`timescale 1ns/1ps
module cosr_regs_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] channel_pending_flags,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic ref_clock_out,
	input wire logic ref_clock_out_oe
);
	import cosr_pkg::*;
	wire a = s_axi_arvalid && s_axi_arready;
	wire o = ref_clock_out;
	wire e = ref_clock_out_oe;
	wire [15:0] f = channel_pending_flags;
	wire [11:0] x = s_axi_araddr;
	wire [31:0] d = s_axi_rdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_oe_write: assert property ($changed(e) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("oe moved");
	chk_off_low: assert property (!e [*3] |-> !o) else $error("off clock");
	chk_high_run: assert property ($rose(o) && e |=> (o || !e) [*5]) else $error("high");
	chk_low_run: assert property ($fell(o) && e |=> (!o || !e) [*5]) else $error("low");
	chk_ar_hold: assert property (a |=> !s_axi_arready) else $error("arready");
	chk_low_sum: assert property (a && x == SUMMARY_LOW_ADDR |=>
		d == {24'h0, $past(f[8:1])}) else $error("sum low");
	chk_high_sum: assert property (a && x == SUMMARY_HIGH_ADDR |=>
		d == {25'h0, $past(f[15:9])}) else $error("sum high");
	chk_first_sum: assert property (a && x == SUMMARY_FIRST_ADDR |=>
		d == {24'h0, $past(f[0]), 7'h0}) else $error("sum first");
endmodule
bind cosr_regs cosr_regs_properties u_chk (.*);

// [cosr_regs_tb.sv]
`timescale 1ns/1ps
module cosr_regs_tb;
	import cosr_pkg::*;
	logic ref_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, pv;
	logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, ref_clock_out, ref_clock_out_oe;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
	logic [15:0] channel_pending_flags = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [11:0] ad [3] = '{SUMMARY_LOW_ADDR, SUMMARY_HIGH_ADDR, SUMMARY_FIRST_ADDR};
	int err_total = 0, n_checks = 0, n, k;
	cosr_regs u_cosr_regs (.*);
	always #20 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] sx(input int j, input logic [15:0] f);
		return j == 0 ? {24'h0, f[8:1]} : j == 1 ? {25'h0, f[15:9]} : {24'h0, f[0], 7'h0};
	endfunction
	task automatic io(input bit w, input logic [11:0] a, input logic [7:0] v);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk);
			if (w ? s_axi_bvalid : s_axi_rvalid) break;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		got = w ? {s_axi_bresp, 30'h0} : {s_axi_rresp, s_axi_rdata[29:0]};
		if (k == 50) begin
			err_total++;
			end_sim();
		end
	endtask
	initial begin
		void'($urandom(56079));
		repeat (3) @(posedge ref_clk);
		rst <= 0;
		io(0, CLOCK_CTRL_ADDR, 0);
		chk(got, 32'h4);
		io(0, 12'h7FC, 0);
		chk(got, {RESP_DECERR, 30'h0});
		for (int i = 0; i < 6; i++) begin
			channel_pending_flags <= i == 0 ? 16'h0 : i == 1 ? 16'hFFFF : 16'($urandom);
			for (int j = 0; j < 3; j++) begin
				io(1, ad[j], 8'($urandom));
				chk(got, 0);
				io(0, ad[j], 0);
				chk(got, sx(j, channel_pending_flags));
			end
		end
		for (int i = 0; i < 3; i++) begin
			io(1, CLOCK_CTRL_ADDR, {4'h0, i < 2, i != 1, 2'h0});
			n = 0;
			repeat (3200) begin
				@(posedge ref_clk);
				n += int'(ref_clock_out !== pv);
				pv = ref_clock_out;
			end
			chk(n / 200, i == 0 ? 2 : 0);
			chk(ref_clock_out_oe, i < 2);
			chk(32'(n >= (i == 0 ? 480 : i == 1 ? 1 : 0) && n <= (i == 0 ? 560 : i == 1 ? 4 : 1)), 1);
			io(0, CLOCK_CTRL_ADDR, 0);
			chk(got, {28'h0, i < 2, i != 1, 2'h0});
		end
		end_sim();
	end
endmodule
